// [cft_pkg.sv]
// Package of constants for the CCD front end timing interface
package cft_pkg;
    localparam int RESULT_WIDTH = 10;
    localparam int SAMPLE_WIDTH = 12;
    localparam logic [9:0] BLACK_OFFSET = 10'h020;
    localparam logic [9:0] NEG_FULL_SCALE = 10'h000;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [11:0] SAMPLE_RESET = 12'h000;
    localparam logic [11:0] TRIM_RESET = 12'h000;
    localparam logic [11:0] TRIM_STEP = 12'h001;
    localparam logic [9:0] BLACK_TARGET = 10'h020;
    localparam int LATENCY_STAGES = 5;
    typedef enum logic [2:0] {
        CFT_ST_RUN = 3'h1,
        CFT_ST_CAL = 3'h2,
        CFT_ST_SLEEP = 3'h4
    } cft_state_type;
endpackage

// [cft_edge_sync.sv]
// Two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module cft_edge_sync (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // First flop read only by the second
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out  = sync_q & ~last_q;
    assign fall_out  = ~sync_q & last_q;
endmodule // cft_edge_sync

// [cft_frontend.sv]
// Digital sampling, calibration and readout of the CCD front end
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Result word changes on each falling edge of the converter clock outside power-down
// - Ten-bit result, msb on line one, lsb on line ten
// - Power-down select high reduces power, low runs normally
// - Black mode low forces negative full scale plus 32 codes
// - Dummy clamp asserted runs input auto-zero of sampling stage
// - Optical black clamp runs output auto-zero of remaining offset
// - Reset strobe captures reset level into second hold stage
// - Video strobe captures video into first, copies second into third
// - Pixel value is difference of paired reset and video samples
module cft_frontend #(
    parameter int WIDTH = cft_pkg::RESULT_WIDTH,
    parameter int SWIDTH = cft_pkg::SAMPLE_WIDTH
) (
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic [SWIDTH-1:0] sensor_level,
    input  wire logic              reset_level_strobe,
    input  wire logic              video_level_strobe,
    input  wire logic              converter_clock,
    input  wire logic              dummy_pixel_clamp_n,
    input  wire logic              optical_black_clamp_n,
    input  wire logic              power_down_select,
    input  wire logic              black_level_mode_select,
    output logic [WIDTH-1:0]       result_word,
    output logic                   result_bit_msb,
    output logic                   result_bit_lsb,
    output logic                   reduced_power,
    output logic                   calibrating
);
    //////////////////////////////////////////////////////////////////////////
    logic rs_lvl, rs_rise, vs_lvl, vs_rise, ck_lvl, ck_fall;
    logic dc_lvl, ob_lvl, pd_lvl, pb_lvl;
    logic [SWIDTH-1:0] sens_m_q, sens_q;

    cft_edge_sync u_rs (.ref_clk(ref_clk), .resetn(resetn),
        .pin_in(reset_level_strobe), .level_out(rs_lvl),
        .rise_out(rs_rise), .fall_out());
    cft_edge_sync u_vs (.ref_clk(ref_clk), .resetn(resetn),
        .pin_in(video_level_strobe), .level_out(vs_lvl),
        .rise_out(vs_rise), .fall_out());
    cft_edge_sync u_ck (.ref_clk(ref_clk), .resetn(resetn),
        .pin_in(converter_clock), .level_out(ck_lvl),
        .rise_out(), .fall_out(ck_fall));
    cft_edge_sync u_dc (.ref_clk(ref_clk), .resetn(resetn),
        .pin_in(dummy_pixel_clamp_n), .level_out(dc_lvl),
        .rise_out(), .fall_out());
    cft_edge_sync u_ob (.ref_clk(ref_clk), .resetn(resetn),
        .pin_in(optical_black_clamp_n), .level_out(ob_lvl),
        .rise_out(), .fall_out());
    cft_edge_sync u_pd (.ref_clk(ref_clk), .resetn(resetn),
        .pin_in(power_down_select), .level_out(pd_lvl),
        .rise_out(), .fall_out());
    cft_edge_sync u_pb (.ref_clk(ref_clk), .resetn(resetn),
        .pin_in(black_level_mode_select), .level_out(pb_lvl),
        .rise_out(), .fall_out());

    // Sensor level delayed to match the strobe synchronisers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sens_m_q <= cft_pkg::SAMPLE_RESET;
            sens_q   <= cft_pkg::SAMPLE_RESET;
        end else begin
            sens_m_q <= sensor_level;
            sens_q   <= sens_m_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Mode state
    cft_pkg::cft_state_type state_q, state_d;
    always_comb begin
        case (1'b1)
            pd_lvl:            state_d = cft_pkg::CFT_ST_SLEEP;
            (!dc_lvl||!ob_lvl): state_d = cft_pkg::CFT_ST_CAL;
            default:           state_d = cft_pkg::CFT_ST_RUN;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!resetn) state_q <= cft_pkg::CFT_ST_RUN;
        else state_q <= state_d;
    end
    logic sleeping;
    assign sleeping = (state_q == cft_pkg::CFT_ST_SLEEP);

    //////////////////////////////////////////////////////////////////////////
    // Three track/hold stages
    logic [SWIDTH-1:0] th1_q, th2_q, th3_q;
    logic pair_q;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            th1_q  <= cft_pkg::SAMPLE_RESET;
            th2_q  <= cft_pkg::SAMPLE_RESET;
            th3_q  <= cft_pkg::SAMPLE_RESET;
            pair_q <= 1'b0;
        end else begin
            pair_q <= 1'b0;
            if (rs_rise && !sleeping) th2_q <= sens_q;
            if (vs_rise && !sleeping) begin
                th1_q  <= sens_q;
                th3_q  <= th2_q;
                pair_q <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Auto-zero trims; input loop on dummy clamp, output loop on black clamp
    logic signed [SWIDTH+1:0] diff;
    logic [SWIDTH-1:0] in_trim_q, out_trim_q;
    logic [WIDTH-1:0] raw;

    // Reset minus video: brighter pixels give larger codes
    assign diff = $signed({2'b00, th3_q}) - $signed({2'b00, th1_q})
                  - $signed({2'b00, in_trim_q});

    function automatic logic [WIDTH-1:0] clip(
        input logic signed [SWIDTH+1:0] v);
        if (v < 0) clip = '0;
        else if (v > $signed({2'b00, {WIDTH{1'b1}}}))
            clip = {WIDTH{1'b1}};
        else clip = v[WIDTH-1:0];
    endfunction

    logic signed [SWIDTH+1:0] corr;
    assign corr = diff - $signed({2'b00, out_trim_q})
                  + $signed({{(SWIDTH+2-WIDTH){1'b0}}, cft_pkg::BLACK_TARGET});
    assign raw = clip(corr);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            in_trim_q  <= cft_pkg::TRIM_RESET;
            out_trim_q <= cft_pkg::TRIM_RESET;
        end else if (pair_q && !sleeping) begin
            // One step per pixel keeps the loop slow and stable
            if (!dc_lvl) begin
                if (diff > 0) in_trim_q <= in_trim_q + cft_pkg::TRIM_STEP;
                else if (diff < 0)
                    in_trim_q <= in_trim_q - cft_pkg::TRIM_STEP;
            end
            if (!ob_lvl) begin
                if (raw > cft_pkg::BLACK_TARGET)
                    out_trim_q <= out_trim_q + cft_pkg::TRIM_STEP;
                else if (raw < cft_pkg::BLACK_TARGET)
                    out_trim_q <= out_trim_q - cft_pkg::TRIM_STEP;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Converter pipeline, advanced by falling converter clock edges
    logic [WIDTH-1:0] pipe_q [cft_pkg::LATENCY_STAGES];
    logic [WIDTH-1:0] conv_in;
    logic [WIDTH-1:0] out_q;
    assign conv_in = pb_lvl ? raw
        : cft_pkg::NEG_FULL_SCALE + cft_pkg::BLACK_OFFSET;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            for (int i = 0; i < cft_pkg::LATENCY_STAGES; i++)
                pipe_q[i] <= cft_pkg::RESULT_RESET;
            out_q <= cft_pkg::RESULT_RESET;
        end else if (ck_fall && !sleeping) begin
            pipe_q[0] <= conv_in;
            for (int i = 1; i < cft_pkg::LATENCY_STAGES; i++)
                pipe_q[i] <= pipe_q[i-1];
            out_q <= pipe_q[cft_pkg::LATENCY_STAGES-1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            result_word    <= cft_pkg::RESULT_RESET;
            result_bit_msb <= 1'b0;
            result_bit_lsb <= 1'b0;
            reduced_power  <= 1'b0;
            calibrating    <= 1'b0;
        end else begin
            result_word    <= out_q;
            result_bit_msb <= out_q[WIDTH-1];
            result_bit_lsb <= out_q[0];
            reduced_power  <= (state_d == cft_pkg::CFT_ST_SLEEP);
            calibrating    <= (state_d == cft_pkg::CFT_ST_CAL);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    a_black_forced: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!pb_lvl && ck_fall && !sleeping) |=>
            pipe_q[0] == cft_pkg::NEG_FULL_SCALE + cft_pkg::BLACK_OFFSET)
        else $error("black mode value wrong");
    a_out_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        !ck_fall |=> $stable(out_q))
        else $error("result moved without clock fall");
    a_msb_map: assert property (@(posedge ref_clk) disable iff (!resetn)
        ##1 result_bit_msb == $past(out_q[WIDTH-1]))
        else $error("msb mapping wrong");
    a_pd_sleep: assert property (@(posedge ref_clk) disable iff (!resetn)
        pd_lvl |=> reduced_power)
        else $error("power down not entered");
    a_th2_take: assert property (@(posedge ref_clk) disable iff (!resetn)
        (rs_rise && !sleeping) |=> th2_q == $past(sens_q))
        else $error("reset level not held");
    a_th3_pair: assert property (@(posedge ref_clk) disable iff (!resetn)
        (vs_rise && !sleeping) |=> th3_q == $past(th2_q)
            && th1_q == $past(sens_q))
        else $error("video pair wrong");
    a_in_trim: assert property (@(posedge ref_clk) disable iff (!resetn)
        dc_lvl |=> $stable(in_trim_q))
        else $error("input trim moved outside dummy clamp");
    a_out_trim: assert property (@(posedge ref_clk) disable iff (!resetn)
        ob_lvl |=> $stable(out_trim_q))
        else $error("output trim moved outside black clamp");
endmodule // cft_frontend

// [cft_timing_gen.sv]
// Model of the timing generator at the far side of the front end
`timescale 1ns/1ps
module cft_timing_gen (
    input  wire logic   ref_clk,
    output logic [11:0] sensor_level,
    output logic        reset_level_strobe,
    output logic        video_level_strobe,
    output logic        converter_clock,
    output logic        dummy_pixel_clamp_n,
    output logic        optical_black_clamp_n
);
    initial begin
        sensor_level = 12'h000;
        reset_level_strobe = 1'b1;
        video_level_strobe = 1'b1;
        converter_clock = 1'b1;
        dummy_pixel_clamp_n = 1'b1;
        optical_black_clamp_n = 1'b1;
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Level held past the rising edge so the synchroniser sees it settle
    task automatic sample(input logic [11:0] v, input logic is_video);
        @(posedge ref_clk) sensor_level <= v;
        hold(3);
        if (is_video) video_level_strobe <= 1'b0;
        else reset_level_strobe <= 1'b0;
        hold(4);
        reset_level_strobe <= 1'b1;
        video_level_strobe <= 1'b1;
        hold(4);
        // Released line shows the inverse, never a stale value
        sensor_level <= ~v;
    endtask
    task automatic pixel(input logic [11:0] r, input logic [11:0] v);
        sample(r, 1'b0);
        sample(v, 1'b1);
    endtask
    task automatic fall_edges(input int n);
        repeat (n) begin
            @(posedge ref_clk) converter_clock <= 1'b0;
            hold(4);
            converter_clock <= 1'b1;
            hold(4);
        end
    endtask
    task automatic clamps(input logic d, input logic o);
        @(posedge ref_clk) dummy_pixel_clamp_n <= d;
        optical_black_clamp_n <= o;
    endtask
endmodule // cft_timing_gen

// [tb_cft_frontend.sv]
// Self-checking testbench for the CCD front end timing interface
`timescale 1ns/1ps
module tb_cft_frontend;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        power_down_select = 1'b0;
    logic        black_level_mode_select = 1'b1;
    logic [11:0] sensor_level;
    logic        reset_level_strobe;
    logic        video_level_strobe;
    logic        converter_clock;
    logic        dummy_pixel_clamp_n;
    logic        optical_black_clamp_n;
    logic [9:0]  result_word;
    logic        result_bit_msb;
    logic        result_bit_lsb;
    logic        reduced_power;
    logic        calibrating;
    int          error_cnt = 0;
    int          samples_checked = 0;
    logic [11:0] rst_tab [4] = '{12'h151, 12'h100, 12'h100, 12'hFFF};
    logic [11:0] vid_tab [4] = '{12'h100, 12'h100, 12'h150, 12'h000};
    logic [9:0]  exp_tab [4] = '{10'h071, 10'h020, 10'h000, 10'h3FF};

    always #10 ref_clk = ~ref_clk;
    //////////////////////////////////////////////////////////////////////////
    cft_timing_gen tg_i (.ref_clk(ref_clk), .sensor_level(sensor_level),
        .reset_level_strobe(reset_level_strobe),
        .video_level_strobe(video_level_strobe),
        .converter_clock(converter_clock),
        .dummy_pixel_clamp_n(dummy_pixel_clamp_n),
        .optical_black_clamp_n(optical_black_clamp_n));
    cft_frontend cft_frontend_i (.ref_clk(ref_clk), .resetn(resetn),
        .sensor_level(sensor_level),
        .reset_level_strobe(reset_level_strobe),
        .video_level_strobe(video_level_strobe),
        .converter_clock(converter_clock),
        .dummy_pixel_clamp_n(dummy_pixel_clamp_n),
        .optical_black_clamp_n(optical_black_clamp_n),
        .power_down_select(power_down_select),
        .black_level_mode_select(black_level_mode_select),
        .result_word(result_word), .result_bit_msb(result_bit_msb),
        .result_bit_lsb(result_bit_lsb), .reduced_power(reduced_power),
        .calibrating(calibrating));
    //////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [9:0] seen,
                         input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic settle();
        tg_i.fall_edges(8);
        repeat (6) @(posedge ref_clk);
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge ref_clk);
        check("reset result", result_word, 10'h000);
        check("reset power", {9'h000, reduced_power}, 10'h000);
        @(posedge ref_clk) resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            tg_i.pixel(rst_tab[i], vid_tab[i]);
            settle();
            check("result_word", result_word, exp_tab[i]);
            check("msb", 10'(result_bit_msb), 10'(exp_tab[i][9]));
            check("lsb", 10'(result_bit_lsb), 10'(exp_tab[i][0]));
        end
        // Late pixel overwrites only once its own video strobe arrives
        tg_i.pixel(12'h180, 12'h100);
        settle();
        check("pair", result_word, 10'h0A0);
        @(posedge ref_clk) black_level_mode_select <= 1'b0;
        settle();
        check("black level", result_word, 10'h020);
        @(posedge ref_clk) black_level_mode_select <= 1'b1;
        @(posedge ref_clk) power_down_select <= 1'b1;
        repeat (5) @(posedge ref_clk);
        check("powered down", {9'h000, reduced_power}, 10'h001);
        tg_i.pixel(12'h300, 12'h100);
        settle();
        check("frozen", result_word, 10'h020);
        @(posedge ref_clk) power_down_select <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check("awake", {9'h000, reduced_power}, 10'h000);
        // One pair per clamp phase, so each trim moves by one step
        tg_i.clamps(1'b0, 1'b1);
        repeat (5) @(posedge ref_clk);
        check("dummy cal", {9'h000, calibrating}, 10'h001);
        tg_i.pixel(12'h110, 12'h100);
        settle();
        check("input trim", result_word, 10'h02F);
        tg_i.clamps(1'b1, 1'b0);
        repeat (5) @(posedge ref_clk);
        check("black cal", {9'h000, calibrating}, 10'h001);
        tg_i.pixel(12'h110, 12'h100);
        settle();
        check("output trim", result_word, 10'h02E);
        tg_i.clamps(1'b1, 1'b1);
        repeat (5) @(posedge ref_clk);
        check("no cal", {9'h000, calibrating}, 10'h000);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        final_report();
    end
endmodule // tb_cft_frontend
